/* ees_cfg.svh */
// Purpose: constants for the serial memory slave and its bus master
// Assumes: 10 MHz core clock
// Notes: included by both ends
`ifndef EES_CFG_SVH
`define EES_CFG_SVH
`define EES_DEV_CODE 4'ha
`define EES_ADDR_W 8
`define EES_MEM_DEPTH 256
`define EES_PAGE_W 4
`define EES_PROG_CYCLES 2000
`define EES_SCL_HALF 8'd4
`define EES_BIT_LAST 4'h8
`define EES_BIT_ACK 4'h9
`endif

/* ees_pkg.sv */
// Purpose: shared types of the serial memory link
// Assumes: nothing
// Notes: constants live in ees_cfg.svh
package ees_pkg;
  typedef enum logic [1:0] {
    EES_OP_WRITE = 2'h0,
    EES_OP_READ = 2'h1,
    EES_OP_POLL = 2'h2
  } ees_op_t;
endpackage

/* ees_if.sv */
// Purpose: two-wire link between master and memory slave
// Assumes: open-drain wires with pull-ups
// Notes: wire level is low when any end enables its driver
`timescale 1ns/1ps
interface ees_if;
  logic scl_m_oe;
  logic sda_m_oe;
  logic sda_s_oe;
  logic scl;
  logic sda;
  assign scl = !scl_m_oe;
  assign sda = !(sda_m_oe || sda_s_oe);
  modport slave (input scl, input sda, output sda_s_oe);
  modport master (input scl, input sda, output scl_m_oe, output sda_m_oe);
endinterface

/* ees_slave.sv */
// Purpose: memory slave end of the two-wire link
// Assumes: scl and sda asynchronous, sampled by two flops
// Notes: 256 bytes, 16-byte page buffer, programming delay in cycles
//
// Behaviour
// (R1) upper address nibble must equal device code
// (R2) address lsb one reads, zero writes
// (R3) acknowledge address only on match
// (R4) receiver pulls sda low on ninth clock
// (R5) acknowledge every written byte unless protected
// (R6) read: release sda, sample master acknowledge
// (R7) byte write: start, address, word, data, stop
// (R8) stop after write starts programming, ignore bus
// (R9) page write carries up to sixteen bytes
// (R10) page write increments only low address bits
// (R11) over sixteen bytes wraps, overwrites earlier bytes
// (R12) busy withholds address acknowledge while programming
// (R13) protect: ack addresses, nack data, no program
// (R14) counter holds last address plus one, wraps
// (R15) current read: ack, one byte, nack, stop
// (R16) random read: dummy write, restart, read
// (R17) sequential read increments full address
// (R18) start and stop detected with scl high
// (R19) sda stable while scl high
// (R20) supervisory reset aborts transfers, lets programming finish
// (R21) programming duration parameter, busy held throughout
`include "ees_cfg.svh"
`timescale 1ns/1ps
module ees_slave #(
  parameter int PROG_CYCLES = `EES_PROG_CYCLES
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic wp_i,
  input wire logic sup_rst_i,
  // status
  output logic busy_o,
  // link
  ees_if.slave bus
);
  typedef enum logic [2:0] {
    EES_S_IDLE = 3'h0,
    EES_S_ADDR = 3'h1,
    EES_S_WORD = 3'h2,
    EES_S_DATA = 3'h3,
    EES_S_READ = 3'h4,
    EES_S_WAIT = 3'h5
  } ees_sst_t;

  logic [7:0] mem [`EES_MEM_DEPTH];
  logic [7:0] page_q [16];
  logic [15:0] pvld_q;
  logic [1:0] scl_s_q, sda_s_q;
  logic scl_p_q, sda_p_q;
  ees_sst_t st_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic [7:0] ptr_q;
  logic [7:0] pbase_q;
  logic wr_q, ack_q, oe_q, pend_q;
  logic [31:0] pcnt_q;

  function automatic logic [7:0] ees_inc(input logic [7:0] a);
    ees_inc = a + 8'h01;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // synchronise and detect edges
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[0], bus.scl};
      sda_s_q <= {sda_s_q[0], bus.sda};
      scl_p_q <= scl_s_q[1];
      sda_p_q <= sda_s_q[1];
    end
  end
  wire scl_w = scl_s_q[1];
  wire sda_w = sda_s_q[1];
  wire scl_rise = scl_w && !scl_p_q;
  wire scl_fall = !scl_w && scl_p_q;
  wire start_w = scl_w && scl_p_q && !sda_w && sda_p_q; // see (R18)
  wire stop_w = scl_w && scl_p_q && sda_w && !sda_p_q; // see (R18) (R19)
  wire busy_w = pcnt_q != 32'h0;
  assign busy_o = busy_w;

  ////////////////////////////////////////////////////////////////////
  // protocol engine
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st_q <= EES_S_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      pbase_q <= 8'h00;
      wr_q <= 1'b0;
      ack_q <= 1'b0;
      oe_q <= 1'b0;
      pvld_q <= 16'h0000;
      pend_q <= 1'b0;
    end else if (sup_rst_i) begin
      st_q <= EES_S_IDLE; // see (R20)
      oe_q <= 1'b0;
      pvld_q <= 16'h0000;
      pend_q <= 1'b0;
    end else if (start_w) begin
      st_q <= busy_w ? EES_S_IDLE : EES_S_ADDR; // see (R8) (R12)
      // the start's own scl fall wraps this to zero
      bit_q <= 4'hf;
      oe_q <= 1'b0;
    end else if (stop_w) begin
      st_q <= EES_S_IDLE;
      oe_q <= 1'b0;
      if (pvld_q != 16'h0000 && !wp_i)
        pend_q <= 1'b1; // see (R8) (R9)
      else
        pvld_q <= 16'h0000;
    end else begin
      if (pend_q)
        pend_q <= 1'b0;
      if (pend_q)
        pvld_q <= 16'h0000;
      if (st_q != EES_S_IDLE && st_q != EES_S_WAIT) begin
        if (scl_rise && bit_q < `EES_BIT_LAST) begin
          sh_q <= {sh_q[6:0], sda_w};
        end
        if (scl_rise && bit_q == `EES_BIT_LAST) begin
          ack_q <= !sda_w; // see (R6)
        end
        if (scl_fall) begin
          bit_q <= (bit_q == `EES_BIT_LAST) ? 4'h0 : bit_q + 4'h1;
          oe_q <= 1'b0;
          if (st_q == EES_S_READ && bit_q < 4'h7) begin
            // own bit shifts back in, so msb is always next
            oe_q <= !sh_q[7];
          end
          if (bit_q == 4'h7) begin
            unique case (st_q)
              EES_S_ADDR: begin
                if (sh_q[7:4] == `EES_DEV_CODE) begin // see (R1) (R3)
                  oe_q <= 1'b1; // see (R4)
                  wr_q <= !sh_q[0]; // see (R2)
                  if (sh_q[0]) begin
                    sh_q <= mem[ptr_q];
                  end
                end else begin
                  st_q <= EES_S_WAIT;
                end
              end
              EES_S_WORD: begin
                oe_q <= 1'b1; // see (R13)
                ptr_q <= sh_q; // see (R16)
                pbase_q <= sh_q;
              end
              EES_S_DATA: begin
                oe_q <= !wp_i; // see (R5) (R13)
                if (!wp_i) begin
                  page_q[ptr_q[3:0]] <= sh_q; // see (R11)
                  pvld_q[ptr_q[3:0]] <= 1'b1;
                  ptr_q <= {ptr_q[7:4], ptr_q[3:0] + 4'h1}; // see (R10)
                end
              end
              EES_S_READ: oe_q <= 1'b0;
              default: oe_q <= 1'b0;
            endcase
          end
          if (bit_q == `EES_BIT_LAST) begin
            unique case (st_q)
              EES_S_ADDR: begin
                st_q <= wr_q ? EES_S_WORD : EES_S_READ;
                if (!wr_q) begin
                  oe_q <= !sh_q[7];
                end
              end
              EES_S_WORD: st_q <= EES_S_DATA;
              EES_S_DATA: st_q <= wp_i ? EES_S_WAIT : EES_S_DATA;
              EES_S_READ: begin
                ptr_q <= ees_inc(ptr_q); // see (R14) (R17)
                if (ack_q) begin
                  sh_q <= mem[ees_inc(ptr_q)];
                  oe_q <= !mem[ees_inc(ptr_q)][7];
                end else begin
                  st_q <= EES_S_WAIT; // see (R6) (R15)
                end
              end
              default: st_q <= EES_S_WAIT;
            endcase
          end
        end
      end
    end
  end
  assign bus.sda_s_oe = oe_q;

  ////////////////////////////////////////////////////////////////////
  // programming cycle and array
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pcnt_q <= 32'h0;
    end else if (pend_q) begin
      pcnt_q <= 32'(PROG_CYCLES); // see (R21)
    end else if (busy_w) begin
      pcnt_q <= pcnt_q - 32'h1; // see (R20)
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (pend_q) begin
      for (int i = 0; i < 16; i++) begin
        if (pvld_q[i])
          mem[{pbase_q[7:4], 4'(i)}] <= page_q[i]; // see (R9)
      end
    end
  end
endmodule

/* ees_master.sv */
// Purpose: bus master end driving the memory slave
// Assumes: commands queue in a two-entry buffer
// Notes: scl made by divider from core clock
`include "ees_cfg.svh"
`timescale 1ns/1ps
module ees_master (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // command
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire ees_pkg::ees_op_t cmd_op_i,
  input wire logic [7:0] cmd_addr_i,
  input wire logic [7:0] cmd_data_i,
  // answer
  output logic rsp_valid_o,
  input wire logic rsp_ready_i,
  output logic [7:0] rsp_data_o,
  output logic rsp_ack_o,
  // link
  ees_if.master bus
);
  typedef enum logic [1:0] {
    EES_M_IDLE = 2'h0,
    EES_M_BYTE = 2'h1,
    EES_M_STOP = 2'h2
  } ees_mst_t;

  logic [17:0] fq_q [2];
  logic [1:0] fv_q;
  logic fw_q, fr_q;
  ees_mst_t st_q;
  logic [7:0] div_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [1:0] idx_q;
  logic [17:0] cur_q;
  logic [7:0] sh_q;
  logic nak_q, sclo_q, sdao_q;
  logic [1:0] sda_s_q;

  ////////////////////////////////////////////////////////////////////
  // two-entry command buffer
  wire push = cmd_valid_i && cmd_ready_o;
  // start only on a tick: bus free time and start hold of one tick, a quarter scl period
  wire pop = fv_q[fr_q] && st_q == EES_M_IDLE && !rsp_valid_o && tick;
  assign cmd_ready_o = !fv_q[fw_q];
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      fv_q <= 2'h0;
      fw_q <= 1'b0;
      fr_q <= 1'b0;
    end else begin
      if (push) begin
        fq_q[fw_q] <= {cmd_op_i, cmd_addr_i, cmd_data_i};
        fv_q[fw_q] <= 1'b1;
        fw_q <= !fw_q;
      end
      if (pop) begin
        fv_q[fr_q] <= 1'b0;
        fr_q <= !fr_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // bit engine: idx 0 address, 1 word (read data on a read), 2 data
  wire tick = div_q == `EES_SCL_HALF;
  wire is_rd = cur_q[17:16] == ees_pkg::EES_OP_READ;
  wire last_b = idx_q == (cur_q[17:16] == ees_pkg::EES_OP_WRITE ? 2'h2 :
                          2'h0);
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) sda_s_q <= 2'h3;
    else sda_s_q <= {sda_s_q[0], bus.sda};
  end
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st_q <= EES_M_IDLE;
      div_q <= 8'h00;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      idx_q <= 2'h0;
      cur_q <= 18'h0;
      sh_q <= 8'h00;
      nak_q <= 1'b0;
      sclo_q <= 1'b1;
      sdao_q <= 1'b1;
      rsp_valid_o <= 1'b0;
      rsp_data_o <= 8'h00;
      rsp_ack_o <= 1'b0;
    end else begin
      if (rsp_valid_o && rsp_ready_i) rsp_valid_o <= 1'b0;
      div_q <= tick ? 8'h00 : div_q + 8'h01;
      if (pop) begin
        cur_q <= fq_q[fr_q];
        sdao_q <= 1'b0; // start, see (R18)
        st_q <= EES_M_BYTE;
        ph_q <= 2'h0;
        bit_q <= 4'h0;
        idx_q <= 2'h0;
        nak_q <= 1'b0;
        sh_q <= {`EES_DEV_CODE, 3'h0,
                 fq_q[fr_q][17:16] == ees_pkg::EES_OP_READ}; // see (R2)
      end else if (tick && st_q == EES_M_BYTE) begin
        ph_q <= ph_q + 2'h1;
        unique case (ph_q)
          2'h0: begin
            sclo_q <= 1'b0;
          end
          2'h1: begin
            if (bit_q < `EES_BIT_LAST) sdao_q <= (is_rd && idx_q != 2'h0)
                                                 ? 1'b1 : sh_q[7]; // see (R19)
            else sdao_q <= !(is_rd && idx_q != 2'h0 && 1'b0);
          end
          2'h2: begin
            sclo_q <= 1'b1;
          end
          2'h3: begin
            ph_q <= 2'h0;
            if (bit_q < `EES_BIT_LAST) begin
              sh_q <= {sh_q[6:0], sda_s_q[1]};
              bit_q <= bit_q + 4'h1;
            end else begin
              bit_q <= 4'h0;
              if (sda_s_q[1]) nak_q <= 1'b1; // see (R4) (R12)
              if (sda_s_q[1] || last_b || (is_rd && idx_q == 2'h1)) begin
                if (is_rd && idx_q == 2'h1) rsp_data_o <= sh_q;
                st_q <= EES_M_STOP; // see (R7) (R15)
              end else begin
                idx_q <= idx_q + 2'h1;
                sh_q <= idx_q == 2'h0 ? cur_q[15:8] : cur_q[7:0];
              end
              if (is_rd && idx_q == 2'h0 && !sda_s_q[1]) begin
                st_q <= EES_M_BYTE;
                idx_q <= 2'h1;
                sh_q <= 8'hff;
              end
            end
          end
          default: ph_q <= 2'h0;
        endcase
      end else if (tick && st_q == EES_M_STOP) begin
        ph_q <= ph_q + 2'h1;
        unique case (ph_q)
          2'h0: sclo_q <= 1'b0;
          2'h1: sdao_q <= 1'b0;
          2'h2: sclo_q <= 1'b1;
          2'h3: begin
            sdao_q <= 1'b1; // stop, see (R18)
            st_q <= EES_M_IDLE;
            rsp_valid_o <= 1'b1;
            rsp_ack_o <= !nak_q;
            ph_q <= 2'h0;
          end
          default: ph_q <= 2'h0;
        endcase
      end
    end
  end
  assign bus.scl_m_oe = !sclo_q;
  assign bus.sda_m_oe = !sdao_q;
endmodule

/* ees_link_props.sv */
// Purpose: concurrent checks on the two-wire link between both ends
// Assumes: counters restart on every start condition
// Notes: watches only the interface wires
`include "ees_cfg.svh"
`timescale 1ns/1ps
module ees_link_props (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // link wires
  input wire logic scl_m_oe,
  input wire logic sda_m_oe,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  localparam logic [3:0] DEV = `EES_DEV_CODE;
  logic scl_q, sda_q, rd_q, rise, start;
  logic [3:0] bit_q;
  logic [1:0] byte_q;
  assign rise = scl && !scl_q;
  assign start = scl && scl_q && sda_q && !sda;
  always_ff @(posedge core_clk_i) begin
    scl_q <= scl;
    sda_q <= sda;
  end
  // bit_q counts rises of the byte so far, byte_q the byte in the frame
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || start) begin
      bit_q <= 4'h0;
      byte_q <= 2'h0;
    end else if (rise) begin
      bit_q <= (bit_q == 4'h9) ? 4'h1 : bit_q + 4'h1;
      if (bit_q == 4'h9 && byte_q != 2'h3) byte_q <= byte_q + 2'h1;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || start) rd_q <= 1'b0;
    else if (rise && byte_q == 2'h0 && bit_q == 4'h7) rd_q <= sda;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_code_bits_sent: assert property (
    rise && byte_q == 2'h0 && bit_q < 4'h4 |-> sda == DEV[2'(4'h3 - bit_q)])
    else $error("device code bit wrong on wire");
  a_master_ack_free: assert property (
    rise && bit_q == 4'h8 |-> !sda_m_oe)
    else $error("master drives sda in ninth clock");
  a_slave_quiet_rx: assert property (
    rise && bit_q != 4'h8 && !rd_q |-> !sda_s_oe)
    else $error("slave drives sda while receiving");
  a_read_release: assert property (
    rise && bit_q == 4'h8 && rd_q && byte_q != 2'h0 |-> !sda_s_oe)
    else $error("slave holds sda in read ack slot");
  a_start_then_low: assert property (
    scl && $rose(sda_m_oe) |-> ##[1:10] !scl)
    else $error("no clock after start");
  a_stop_then_idle: assert property (
    scl && $past(scl) && $fell(sda_m_oe) |-> (!scl_m_oe && !sda_m_oe) [*4])
    else $error("bus not idle after stop");
  a_nack_then_stop: assert property (
    rise && bit_q == 4'h8 && byte_q == 2'h0 && sda
      |-> ##[1:40] (scl && $rose(sda)))
    else $error("no stop after address nack");
  a_slave_stable_high: assert property (
    scl && $past(scl) |-> $stable(sda_s_oe))
    else $error("slave changes sda while scl high");
  c_read_frame: cover property (rise && bit_q == 4'h8 && rd_q && byte_q != 0);
  c_addr_nack: cover property (rise && bit_q == 4'h8 && byte_q == 0 && sda);
  c_data_ack: cover property (rise && bit_q == 4'h8 && byte_q == 2 && !sda);
endmodule

/* tb_top.sv */
// Purpose: self-checking bench for master and memory slave
// Assumes: second slave on a bench-driven link for page and fault cases
// Notes: programming shortened to 400 cycles
`timescale 1ns/1ps
module tb_top;
  localparam int PROG = 400;
  logic core_clk_i = 0;
  logic rst_n_i = 0;
  logic wp_i = 0;
  logic sup_rst_i = 0;
  logic busy_o, busy2, cmd_ready_o, rsp_valid_o, rsp_ack_o;
  logic cmd_valid_i = 0;
  logic rsp_ready_i = 0;
  ees_pkg::ees_op_t cmd_op_i = ees_pkg::EES_OP_WRITE;
  logic [7:0] cmd_addr_i = 8'h00;
  logic [7:0] cmd_data_i = 8'h00;
  logic [7:0] rsp_data_o;
  logic [7:0] pg [17];
  int n_fail = 0;
  int compares = 0;
  int busy_n = 0;
  ees_if bus ();
  ees_if bb ();
  ees_slave #(.PROG_CYCLES(PROG)) u_ees_slave (.core_clk_i, .rst_n_i,
    .wp_i, .sup_rst_i, .busy_o, .bus(bus));
  ees_slave #(.PROG_CYCLES(PROG)) u_ees_slave_2 (.core_clk_i, .rst_n_i,
    .wp_i(1'b0), .sup_rst_i(1'b0), .busy_o(busy2), .bus(bb));
  ees_master u_ees_master (.core_clk_i, .rst_n_i, .cmd_valid_i,
    .cmd_ready_o, .cmd_op_i, .cmd_addr_i, .cmd_data_i, .rsp_valid_o,
    .rsp_ready_i, .rsp_data_o, .rsp_ack_o, .bus(bus));
  ees_link_props u_ees_link_props (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .scl_m_oe(bus.scl_m_oe), .sda_m_oe(bus.sda_m_oe),
    .sda_s_oe(bus.sda_s_oe), .scl(bus.scl), .sda(bus.sda));
  initial begin
    forever #50 core_clk_i = ~core_clk_i;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  // busy run length of u_ees_slave seen whenever its programming ends
  always @(posedge core_clk_i) begin
    if (busy_o === 1'b1) begin
      busy_n++;
    end else if (busy_n != 0) begin
      chk(busy_n >= PROG, 1'b1);
      busy_n = 0;
    end
  end
  initial begin
    cyc(60000);
    n_fail++;
    $display("mismatch at %0t: timeout", $time);
    tally_and_finish;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic cmd(ees_pkg::ees_op_t op, logic [7:0] a, d,
                     output logic [7:0] q, output logic k);
    int i;
    cmd_op_i = op;
    cmd_addr_i = a;
    cmd_data_i = d;
    cmd_valid_i = 1;
    for (i = 0; i < 50 && cmd_ready_o !== 1'b1; i++) cyc(1);
    cyc(1);
    cmd_valid_i = 0;
    for (i = 0; i < 4000 && rsp_valid_o !== 1'b1; i++) cyc(1);
    q = rsp_data_o;
    k = rsp_ack_o;
    rsp_ready_i = 1;
    cyc(1);
    rsp_ready_i = 0;
  endtask
  task automatic wr(logic [7:0] a, d);
    logic [7:0] q;
    logic k;
    int i;
    cmd(ees_pkg::EES_OP_WRITE, a, d, q, k);
    chk(k, 1);
    cmd(ees_pkg::EES_OP_POLL, a, d, q, k);
    chk(k, 0);
    chk(busy_o, 1);
    for (i = 0; i < 10 && k !== 1'b1; i++)
      cmd(ees_pkg::EES_OP_POLL, a, d, q, k);
    chk(k, 1);
  endtask
  task automatic rd(logic [7:0] e);
    logic [7:0] q;
    logic k;
    cmd(ees_pkg::EES_OP_READ, 8'h00, 8'h00, q, k);
    chk(q, e);
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic bb_bit(logic b, output logic r);
    cyc(1);
    bb.sda_m_oe = !b;
    cyc(3);
    bb.scl_m_oe = 0;
    cyc(4);
    r = bb.sda;
    bb.scl_m_oe = 1;
  endtask
  task automatic bb_start;
    bb.sda_m_oe = 0;
    cyc(2);
    bb.scl_m_oe = 0;
    cyc(4);
    bb.sda_m_oe = 1;
    cyc(4);
    bb.scl_m_oe = 1;
  endtask
  task automatic bb_stop;
    cyc(1);
    bb.sda_m_oe = 1;
    cyc(3);
    bb.scl_m_oe = 0;
    cyc(4);
    bb.sda_m_oe = 0;
    cyc(4);
  endtask
  task automatic bb_byte(logic [7:0] d, output logic ak);
    logic r;
    for (int i = 7; i >= 0; i--) bb_bit(d[i], r);
    bb_bit(1'b1, r);
    ak = !r;
  endtask
  task automatic bb_rd(logic nack, output logic [7:0] q);
    logic r;
    for (int i = 0; i < 8; i++) begin
      bb_bit(1'b1, r);
      q = {q[6:0], r};
    end
    bb_bit(nack, r);
  endtask
  task automatic bb_poll;
    logic ak;
    for (int i = 0; i < 20; i++) begin
      bb_start;
      bb_byte(8'ha0, ak);
      bb_stop;
      if (ak) break;
    end
    chk(ak, 1);
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic t_master;
    wr(8'h00, 8'he1);
    wr(8'hff, 8'h77);
    wr(8'hfe, 8'h5a);
    rd(8'h77);
    rd(8'he1);
    wr(8'h0f, 8'hc3);
    rd(8'he1);
    $display("test master done");
  endtask
  task automatic t_protect;
    logic [7:0] q;
    logic k;
    wr(8'h20, 8'h44);
    wp_i = 1;
    cmd(ees_pkg::EES_OP_WRITE, 8'h20, 8'h99, q, k);
    chk(k, 0);
    cmd(ees_pkg::EES_OP_POLL, 8'h00, 8'h00, q, k);
    chk(k, 1);
    wp_i = 0;
    wr(8'h2f, 8'h11);
    rd(8'h44);
    $display("test protect done");
  endtask
  task automatic t_sup;
    logic [7:0] q;
    logic k;
    sup_rst_i = 1;
    cmd(ees_pkg::EES_OP_WRITE, 8'h30, 8'h66, q, k);
    chk(k, 0);
    chk(busy_o, 0);
    sup_rst_i = 0;
    cmd(ees_pkg::EES_OP_WRITE, 8'h31, 8'h22, q, k);
    // let the slave see the stop before the supervisor steps in
    cyc(5);
    sup_rst_i = 1;
    chk(busy_o, 1);
    cmd(ees_pkg::EES_OP_POLL, 8'h00, 8'h00, q, k);
    chk(k, 0);
    cyc(PROG);
    chk(busy_o, 0);
    sup_rst_i = 0;
    $display("test supervisor done");
  endtask
  task automatic t_page;
    logic ak, r;
    logic [7:0] q;
    bb_start;
    bb_byte(8'h90, ak);
    chk(ak, 0);
    bb_stop;
    bb_start;
    bb_bit(1'b1, r);
    bb_bit(1'b0, r);
    bb_stop;
    bb_start;
    bb_byte(8'ha0, ak);
    chk(ak, 1);
    bb_byte(8'h47, ak);
    for (int i = 0; i < 18; i++) begin
      bb_byte(8'h80 + 8'(i), ak);
      chk(ak, 1);
      pg[(7 + i) % 16] = 8'h80 + 8'(i);
    end
    bb_stop;
    bb_poll;
    bb_start;
    bb_byte(8'ha0, ak);
    bb_byte(8'h50, ak);
    bb_byte(8'hee, ak);
    bb_stop;
    pg[16] = 8'hee;
    bb_poll;
    bb_start;
    bb_byte(8'ha0, ak);
    bb_byte(8'h40, ak);
    bb_start;
    bb_byte(8'ha1, ak);
    chk(ak, 1);
    for (int i = 0; i < 17; i++) begin
      bb_rd(i == 16, q);
      chk(q, pg[i]);
    end
    bb_stop;
    $display("test page done");
  endtask
  initial begin
    bb.scl_m_oe = 0;
    bb.sda_m_oe = 0;
    cyc(5);
    rst_n_i = 1;
    cyc(1);
    t_master;
    t_protect;
    t_sup;
    t_page;
    tally_and_finish;
  end
endmodule
